/* src/torque_limit_pkg.sv */
// torque limit selection and alarm handling: shared constants, register map, helpers
// assumes a 20 MHz system clock and limits expressed in tenths of a percent internally
package torque_limit_pkg;

  // timing
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned UV_TIME_MS    = 100;
  localparam int unsigned UV_CYCLES_DEF = UV_TIME_MS * (CLK_HZ / 1000);

  // analog and supply scaling
  localparam logic [9:0]  UV_BUS_VOLTS   = 10'h0c8;
  localparam logic [10:0] OFFSET_MAX_MV  = 11'h3e7;
  localparam logic [13:0] ANALOG_FULL_MV = 14'h2710;
  localparam logic [6:0]  LIMIT_FULL_PCT = 7'h64;

  // register offsets
  localparam logic [7:0] REG_LIMIT1   = 8'h00;
  localparam logic [7:0] REG_LIMIT2   = 8'h04;
  localparam logic [7:0] REG_OFFSET   = 8'h08;
  localparam logic [7:0] REG_DIR      = 8'h0c;
  localparam logic [7:0] REG_STATE    = 8'h10;
  localparam logic [7:0] REG_ALARM    = 8'h14;
  localparam logic [7:0] REG_IRQ_STAT = 8'h18;
  localparam logic [7:0] REG_IRQ_MASK = 8'h1c;
  localparam logic [7:0] REG_HOME     = 8'h20;
  localparam logic [7:0] REG_ACTIVE   = 8'h24;

  // state register fields
  localparam int unsigned ST_EXT_SEL  = 0;
  localparam int unsigned ST_INT2_SEL = 1;
  localparam int unsigned ST_SERVO    = 2;
  localparam int unsigned ST_BASE     = 3;
  localparam int unsigned ST_LIMITING = 4;
  localparam int unsigned ST_HOME     = 5;
  localparam int unsigned ST_ALARM    = 6;

  // interrupt fields
  localparam int unsigned IRQ_W         = 3;
  localparam int unsigned IRQ_ALARM     = 0;
  localparam int unsigned IRQ_LIMIT     = 1;
  localparam int unsigned IRQ_HOME_LOST = 2;

  // reset values
  localparam logic [6:0]  LIMIT1_RST = 7'h64;
  localparam logic [6:0]  LIMIT2_RST = 7'h64;
  localparam logic [10:0] OFFSET_RST = 11'h000;
  localparam logic        DIR_RST    = 1'b0;

  // alarm codes
  localparam logic [7:0] ALM_NONE        = 8'h00;
  localparam logic [7:0] ALM_UNDERVOLT   = 8'h10;
  localparam logic [7:0] ALM_REGEN       = 8'h30;
  localparam logic [7:0] ALM_OVERCURRENT = 8'h32;
  localparam logic [7:0] ALM_OVERLOAD1   = 8'h50;
  localparam logic [7:0] ALM_OVERLOAD2   = 8'h51;

  function automatic logic [9:0] pct_to_tenths(input logic [6:0] pct);
    pct_to_tenths = 10'({3'h0, pct} * 10'h00a);
  endfunction

  function automatic logic [9:0] min_tenths(input logic [9:0] a, input logic [9:0] b);
    min_tenths = (a < b) ? a : b;
  endfunction

endpackage

/* src/input_sync.sv */
// two-flop synchroniser for a group of asynchronous contact inputs
// assumes each bit is an independent level; no bus coherence
`timescale 1ns/100ps
`default_nettype none
module input_sync #(
  parameter int unsigned W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule
`default_nettype wire

/* src/torque_clamp.sv */
// signed torque clamp against a magnitude limit, per direction enable
// assumes positive command is the counter-clockwise direction
`timescale 1ns/100ps
`default_nettype none
module torque_clamp #(
  parameter int unsigned CMD_W = 16
) (
  input  wire logic signed [CMD_W-1:0] cmd,
  input  wire logic        [9:0]       limit,
  input  wire logic                    pos_en,
  input  wire logic                    neg_en,
  output logic signed      [CMD_W-1:0] clamped,
  output logic                         at_limit
);
  logic signed [CMD_W-1:0] lim_s;

  if (CMD_W < 12) begin : g_cmd_chk
    $error("torque_clamp: CMD_W must be at least 12");
  end

  assign lim_s = signed'({{(CMD_W-10){1'b0}}, limit});

  always_comb begin
    clamped  = cmd;
    at_limit = 1'b0;
    if (pos_en && cmd >= lim_s) begin
      clamped  = lim_s;
      at_limit = 1'b1;
    end else if (neg_en && cmd <= -lim_s) begin
      clamped  = -lim_s;
      at_limit = 1'b1;
    end
  end
endmodule
`default_nettype wire

/* src/torque_limit_select_alarm.sv */
// torque limit selection, command clamp and latched alarm handling for a servo amplifier
// assumes contact inputs are asynchronous pins; adc words and torque command are on sys_clk
// assumes rst_n follows control power, so only a power cycle clears a latched alarm
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - neither select: internal limit one
// - external select: min analog, limit one
// - limit2 select: min limit two, one
// - both selects: min analog, limit two
// - shorted contact reads one, open zero
// - signed millivolt offset added to analog
// - direction digit: both, or ccw only
// - any alarm cuts base drive immediately
// - alarm clears only by power cycle
// - persisting cause re-raises alarm after cycle
// - long control power dip: undervoltage
// - low dc bus: undervoltage alarm
// - distinct codes for each fault kind
// - alarm loses home, homing required
// - limiting flag; cleared by servo off
module torque_limit_select_alarm #(
  parameter int unsigned UV_CYCLES = torque_limit_pkg::UV_CYCLES_DEF,
  parameter int unsigned CMD_W     = 16
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic [7:0]              reg_addr,
  input  wire logic [15:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [15:0]             reg_rdata,
  input  wire logic                    ext_limit_select,
  input  wire logic                    int_limit2_select,
  input  wire logic                    servo_enable_input,
  input  wire logic                    ctrl_power_present,
  input  wire logic                    overcurrent_fault,
  input  wire logic                    overload1_fault,
  input  wire logic                    overload2_fault,
  input  wire logic                    regen_fault,
  input  wire logic [13:0]             analog_limit_input,
  input  wire logic [9:0]              dc_bus_volts,
  input  wire logic                    homing_done,
  input  wire logic signed [CMD_W-1:0] torque_cmd,
  output logic signed      [CMD_W-1:0] torque_out,
  output logic                         torque_limiting_flag,
  output logic                         base_drive_en,
  output logic                         alarm_active,
  output logic      [7:0]              alarm_code,
  output logic                         home_valid,
  output logic                         irq
);

  if (UV_CYCLES < 2) begin : g_uv_chk
    $error("UV_CYCLES must be at least 2");
  end

  // synchronised contacts: index order below
  logic [7:0] pins_s;
  logic       ext_s, int2_s, servo_s, power_s, oc_s, ol1_s, ol2_s, regen_s;

  input_sync #(
    .W (8)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .d       ({regen_fault, overload2_fault, overload1_fault, overcurrent_fault,
                ctrl_power_present, servo_enable_input, int_limit2_select, ext_limit_select}),
    .q       (pins_s)
  );

  // a high level means the contact to common is shorted
  assign {regen_s, ol2_s, ol1_s, oc_s, power_s, servo_s, int2_s, ext_s} = pins_s;

  // software settings
  logic [6:0]           limit1_ff;
  logic [6:0]           limit2_ff;
  logic signed [10:0]   offset_ff;
  logic                 ccw_only_ff;
  localparam int unsigned IRQ_W_L = torque_limit_pkg::IRQ_W;
  logic [IRQ_W_L-1:0]   irq_mask_ff;
  logic [IRQ_W_L-1:0]   irq_stat_ff;

  logic wr_limit1, wr_limit2, wr_offset, wr_dir, wr_mask, wr_home, rd_irq;
  assign wr_limit1 = reg_wr && reg_addr == torque_limit_pkg::REG_LIMIT1;
  assign wr_limit2 = reg_wr && reg_addr == torque_limit_pkg::REG_LIMIT2;
  assign wr_offset = reg_wr && reg_addr == torque_limit_pkg::REG_OFFSET;
  assign wr_dir    = reg_wr && reg_addr == torque_limit_pkg::REG_DIR;
  assign wr_mask   = reg_wr && reg_addr == torque_limit_pkg::REG_IRQ_MASK;
  assign wr_home   = reg_wr && reg_addr == torque_limit_pkg::REG_HOME && reg_wdata[0];
  assign rd_irq    = reg_rd && reg_addr == torque_limit_pkg::REG_IRQ_STAT;

  // limits above full scale saturate at full scale
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      limit1_ff <= torque_limit_pkg::LIMIT1_RST;
      limit2_ff <= torque_limit_pkg::LIMIT2_RST;
    end else begin
      if (wr_limit1) begin
        limit1_ff <= (reg_wdata > 16'(torque_limit_pkg::LIMIT_FULL_PCT)) ?
                     torque_limit_pkg::LIMIT_FULL_PCT : reg_wdata[6:0];
      end
      if (wr_limit2) begin
        limit2_ff <= (reg_wdata > 16'(torque_limit_pkg::LIMIT_FULL_PCT)) ?
                     torque_limit_pkg::LIMIT_FULL_PCT : reg_wdata[6:0];
      end
    end
  end

  // offset is written as a signed 16-bit value and saturated to the legal span
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      offset_ff <= signed'(torque_limit_pkg::OFFSET_RST);
    end else if (wr_offset) begin
      if (signed'(reg_wdata) > signed'(16'(torque_limit_pkg::OFFSET_MAX_MV))) begin
        offset_ff <= signed'(torque_limit_pkg::OFFSET_MAX_MV);
      end else if (signed'(reg_wdata) < -signed'(16'(torque_limit_pkg::OFFSET_MAX_MV))) begin
        offset_ff <= -signed'(torque_limit_pkg::OFFSET_MAX_MV);
      end else begin
        offset_ff <= signed'(reg_wdata[10:0]);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ccw_only_ff <= torque_limit_pkg::DIR_RST;
      irq_mask_ff <= '0;
    end else begin
      if (wr_dir) begin
        ccw_only_ff <= reg_wdata[0];
      end
      if (wr_mask) begin
        irq_mask_ff <= reg_wdata[IRQ_W_L-1:0];
      end
    end
  end

  // analog limit path: offset, saturate to 0..10 V, scale 10 mV per tenth percent
  logic signed [15:0] analog_adj;
  logic [13:0]        analog_mv;
  logic [9:0]         analog_tenths;
  assign analog_adj = signed'({2'h0, analog_limit_input}) + 16'(offset_ff);
  assign analog_mv  = (analog_adj < 0) ? 14'h0000 :
                      (analog_adj > signed'({2'h0, torque_limit_pkg::ANALOG_FULL_MV})) ?
                      torque_limit_pkg::ANALOG_FULL_MV : analog_adj[13:0];
  assign analog_tenths = 10'(analog_mv / 14'h000a);

  // limit selection
  logic [9:0] lim1_t, lim2_t, active_limit;
  assign lim1_t = torque_limit_pkg::pct_to_tenths(limit1_ff);
  assign lim2_t = torque_limit_pkg::pct_to_tenths(limit2_ff);

  always_comb begin
    unique case ({int2_s, ext_s})
      2'b00: active_limit = lim1_t;
      2'b01: active_limit = torque_limit_pkg::min_tenths(analog_tenths, lim1_t);
      2'b10: active_limit = torque_limit_pkg::min_tenths(lim2_t, lim1_t);
      2'b11: active_limit = torque_limit_pkg::min_tenths(analog_tenths, lim2_t);
    endcase
  end

  // positive command is ccw; cw limiting is dropped when the ccw-only digit is set
  logic signed [CMD_W-1:0] clamped;
  logic                    at_limit;
  logic                    cw_limited;
  assign cw_limited = !ccw_only_ff;

  torque_clamp #(
    .CMD_W (CMD_W)
  ) u_clamp (
    .cmd      (torque_cmd),
    .limit    (active_limit),
    .pos_en   (1'b1),
    .neg_en   (cw_limited),
    .clamped  (clamped),
    .at_limit (at_limit)
  );

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      torque_out <= '0;
    end else begin
      torque_out <= clamped;
    end
  end

  // limiting flag only while the servo is enabled
  logic limit_rise;
  assign limit_rise = servo_s && at_limit && !torque_limiting_flag;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      torque_limiting_flag <= 1'b0;
    end else begin
      torque_limiting_flag <= servo_s && at_limit;
    end
  end

  // undervoltage: control power dip timer; a full shutdown arrives as rst_n instead
  logic [31:0] dip_cnt_ff;
  logic        dip_long;
  assign dip_long = dip_cnt_ff >= 32'(UV_CYCLES - 1);

  always_ff @(posedge sys_clk) begin
    if (!rst_n || power_s) begin
      dip_cnt_ff <= '0;
    end else if (!dip_long) begin
      dip_cnt_ff <= dip_cnt_ff + 32'h0000_0001;
    end
  end

  logic bus_low, uv_now;
  assign bus_low = dc_bus_volts <= torque_limit_pkg::UV_BUS_VOLTS;
  assign uv_now  = bus_low || (!power_s && dip_long);

  // first cause found wins the code; overcurrent ranks highest as it is the most harmful
  logic       fault_now;
  logic [7:0] nxt_code;
  assign fault_now = oc_s || ol1_s || ol2_s || regen_s || uv_now;

  always_comb begin
    nxt_code = torque_limit_pkg::ALM_NONE;
    if (oc_s) begin
      nxt_code = torque_limit_pkg::ALM_OVERCURRENT;
    end else if (ol1_s) begin
      nxt_code = torque_limit_pkg::ALM_OVERLOAD1;
    end else if (ol2_s) begin
      nxt_code = torque_limit_pkg::ALM_OVERLOAD2;
    end else if (regen_s) begin
      nxt_code = torque_limit_pkg::ALM_REGEN;
    end else if (uv_now) begin
      nxt_code = torque_limit_pkg::ALM_UNDERVOLT;
    end
  end

  // latch has no clear path except reset; a cause still present re-latches at once
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      alarm_active <= 1'b0;
      alarm_code   <= torque_limit_pkg::ALM_NONE;
    end else if (!alarm_active && fault_now) begin
      alarm_active <= 1'b1;
      alarm_code   <= nxt_code;
    end
  end

  // base drive drops in the same cycle as the fault is seen, before the latch
  assign base_drive_en = servo_s && !alarm_active && !fault_now;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      home_valid <= 1'b0;
    end else if (alarm_active || fault_now) begin
      home_valid <= 1'b0;
    end else if (homing_done || wr_home) begin
      home_valid <= 1'b1;
    end
  end

  // sticky events; a new event in the read cycle survives the read
  logic [IRQ_W_L-1:0] events;
  assign events[torque_limit_pkg::IRQ_ALARM]     = fault_now && !alarm_active;
  assign events[torque_limit_pkg::IRQ_LIMIT]     = limit_rise;
  assign events[torque_limit_pkg::IRQ_HOME_LOST] = home_valid && fault_now;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= (rd_irq ? '0 : irq_stat_ff) | events;
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  // read port: data valid only in the cycle after the strobe, zero elsewhere
  logic [15:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 16'h0000;
    unique case (reg_addr)
      torque_limit_pkg::REG_LIMIT1:   nxt_rdata = {9'h000, limit1_ff};
      torque_limit_pkg::REG_LIMIT2:   nxt_rdata = {9'h000, limit2_ff};
      torque_limit_pkg::REG_OFFSET:   nxt_rdata = 16'(offset_ff);
      torque_limit_pkg::REG_DIR:      nxt_rdata = {15'h0000, ccw_only_ff};
      torque_limit_pkg::REG_STATE: begin
        nxt_rdata[torque_limit_pkg::ST_EXT_SEL]  = ext_s;
        nxt_rdata[torque_limit_pkg::ST_INT2_SEL] = int2_s;
        nxt_rdata[torque_limit_pkg::ST_SERVO]    = servo_s;
        nxt_rdata[torque_limit_pkg::ST_BASE]     = base_drive_en;
        nxt_rdata[torque_limit_pkg::ST_LIMITING] = torque_limiting_flag;
        nxt_rdata[torque_limit_pkg::ST_HOME]     = home_valid;
        nxt_rdata[torque_limit_pkg::ST_ALARM]    = alarm_active;
      end
      torque_limit_pkg::REG_ALARM:    nxt_rdata = {8'h00, alarm_code};
      torque_limit_pkg::REG_IRQ_STAT: nxt_rdata = 16'(irq_stat_ff);
      torque_limit_pkg::REG_IRQ_MASK: nxt_rdata = 16'(irq_mask_ff);
      torque_limit_pkg::REG_HOME:     nxt_rdata = {15'h0000, home_valid};
      torque_limit_pkg::REG_ACTIVE:   nxt_rdata = {6'h00, active_limit};
      default:                        nxt_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? nxt_rdata : 16'h0000;
    end
  end

  a_sel_default: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!int2_s && !ext_s) |-> active_limit == torque_limit_pkg::pct_to_tenths(limit1_ff))
    else $error("default selection is not limit one");

  a_sel_analog: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!int2_s && ext_s) |-> (active_limit <= lim1_t && active_limit <= analog_tenths))
    else $error("external selection exceeds a source");

  a_sel_limit2: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (int2_s && !ext_s) |-> (active_limit <= lim1_t && (active_limit == lim1_t || active_limit == lim2_t)))
    else $error("limit two selection wrong");

  a_sel_both: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (int2_s && ext_s) |-> (active_limit <= lim2_t && active_limit <= analog_tenths))
    else $error("both selections exceed a source");

  a_base_cut: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (fault_now || alarm_active) |-> !base_drive_en)
    else $error("base drive on during alarm");

  a_alarm_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
    alarm_active |=> (alarm_active && $stable(alarm_code)))
    else $error("alarm cleared without power cycle");

  a_uv_bus: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_low |=> alarm_active)
    else $error("low bus voltage raised no alarm");

  a_uv_dip: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (power_s ##1 !power_s) |-> (dip_cnt_ff == 32'h0000_0000))
    else $error("dip timer not restarted");

  a_home_lost: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(alarm_active) |-> !home_valid)
    else $error("home kept across alarm");

  a_flag_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !servo_s |=> !torque_limiting_flag)
    else $error("limiting flag with servo off");

  a_cw_pass: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ccw_only_ff && torque_cmd < 0) |=> torque_out == $past(torque_cmd))
    else $error("cw command clamped while unlimited");

  a_ccw_clamp: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (torque_cmd > 0) |=> torque_out <= signed'({{(CMD_W-10){1'b0}}, $past(active_limit)}))
    else $error("ccw command above limit");

endmodule
`default_nettype wire

/* sim/seq_ctrl_model.sv */
// external sequence controller model driving the amplifier's contact inputs
// assumes the bench sets its wishes right after a rising sys_clk edge
`timescale 1ns/100ps
`default_nettype none
module seq_ctrl_model (
  input  wire logic want_servo,
  input  wire logic want_ext,
  input  wire logic want_int2,
  input  wire logic power_on,
  input  wire logic alarm_active,
  output logic      servo_enable_input,
  output logic      ext_limit_select,
  output logic      int_limit2_select,
  output logic      ctrl_power_present
);
  // shorted contact is a one, open contact a zero
  assign ext_limit_select   = want_ext;
  assign int_limit2_select  = want_int2;
  assign ctrl_power_present = power_on;
  // servo is dropped as soon as an alarm shows, whatever the bench asks
  assign servo_enable_input = want_servo & ~alarm_active;
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench for torque_limit_select_alarm
// assumes the package constants; undervoltage count shortened to 20 cycles
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int unsigned UVC = 20;
  logic               sys_clk = 1'b0;
  logic               rst_n = 1'b0;
  logic        [7:0]  reg_addr = 8'h00;
  logic        [15:0] reg_wdata = 16'h0000;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic        [15:0] reg_rdata;
  logic               want_servo = 1'b0;
  logic               want_ext = 1'b0;
  logic               want_int2 = 1'b0;
  logic               power_on = 1'b1;
  logic        [3:0]  flt = 4'h0;
  logic        [13:0] analog = 14'h0000;
  logic        [9:0]  bus_v = 10'h12c;
  logic               homing_done = 1'b0;
  logic signed [15:0] torque_cmd = 16'sh0000;
  logic signed [15:0] torque_out;
  logic               flag;
  logic               base_en;
  logic               alarm;
  logic        [7:0]  code;
  logic               home;
  logic               irq;
  wire logic          servo_s;
  wire logic          ext_s;
  wire logic          int2_s;
  wire logic          cpp_s;
  int                 miscompares = 0;
  int                 n_tests = 0;

  always #25 sys_clk = ~sys_clk;

  seq_ctrl_model u_ctrl (.want_servo(want_servo), .want_ext(want_ext), .want_int2(want_int2),
    .power_on(power_on), .alarm_active(alarm), .servo_enable_input(servo_s),
    .ext_limit_select(ext_s), .int_limit2_select(int2_s), .ctrl_power_present(cpp_s));

  torque_limit_select_alarm #(.UV_CYCLES(UVC), .CMD_W(16)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_limit_select(ext_s), .int_limit2_select(int2_s), .servo_enable_input(servo_s),
    .ctrl_power_present(cpp_s), .overcurrent_fault(flt[0]), .overload1_fault(flt[1]),
    .overload2_fault(flt[2]), .regen_fault(flt[3]), .analog_limit_input(analog), .dc_bus_volts(bus_v),
    .homing_done(homing_done), .torque_cmd(torque_cmd), .torque_out(torque_out),
    .torque_limiting_flag(flag), .base_drive_en(base_en), .alarm_active(alarm), .alarm_code(code),
    .home_valid(home), .irq(irq));

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk_val(reg_rdata, exp);
  endtask
  // rst_n low stands for control power removed
  task automatic power_cycle();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    tick(8);
    rst_n <= 1'b1;
    tick(3);
  endtask
  task automatic drive_cmd(input logic signed [15:0] c, input logic [15:0] exp);
    tick(1);
    torque_cmd <= c;
    tick(3);
    #1;
    chk_val(torque_out, exp);
  endtask

  task automatic t_reset();
    rd_chk(torque_limit_pkg::REG_LIMIT1, 16'h0064);
    rd_chk(torque_limit_pkg::REG_IRQ_MASK, 16'h0000);
    rd_chk(torque_limit_pkg::REG_ALARM, 16'h0000);
    rd_chk(8'h30, 16'h0000);
    wr(torque_limit_pkg::REG_LIMIT2, 16'h00c8);
    rd_chk(torque_limit_pkg::REG_LIMIT2, 16'h0064);
    wr(torque_limit_pkg::REG_OFFSET, 16'hfc00);
    rd_chk(torque_limit_pkg::REG_OFFSET, 16'hfc19);
  endtask
  task automatic t_select();
    logic [15:0] exp [4];
    exp = '{16'h0258, 16'h01ea, 16'h0190, 16'h0190};
    wr(torque_limit_pkg::REG_LIMIT1, 16'h003c);
    wr(torque_limit_pkg::REG_LIMIT2, 16'h0028);
    wr(torque_limit_pkg::REG_OFFSET, 16'hff9c);
    analog <= 14'h1388;
    for (int i = 0; i < 4; i++) begin
      tick(1);
      {want_int2, want_ext} <= 2'(i);
      tick(4);
      rd_chk(torque_limit_pkg::REG_ACTIVE, exp[i]);
    end
    tick(1);
    {want_int2, want_ext} <= 2'b00;
  endtask
  task automatic t_clamp();
    want_servo <= 1'b1;
    tick(4);
    drive_cmd(16'sd800, 16'h0258);
    chk_bit(flag, 1'b1);
    drive_cmd(-16'sd800, 16'hfda8);
    drive_cmd(16'sd100, 16'h0064);
    wr(torque_limit_pkg::REG_DIR, 16'h0001);
    drive_cmd(-16'sd800, 16'hfce0);
    drive_cmd(16'sd800, 16'h0258);
    tick(1);
    want_servo <= 1'b0;
    torque_cmd <= 16'sh0000;
    tick(5);
    #1;
    chk_bit(flag, 1'b0);
    chk_bit(irq, 1'b0);
    rd_chk(torque_limit_pkg::REG_IRQ_STAT, 16'h0002);
    rd_chk(torque_limit_pkg::REG_IRQ_STAT, 16'h0000);
    wr(torque_limit_pkg::REG_DIR, 16'h0000);
  endtask
  task automatic t_alarm();
    wr(torque_limit_pkg::REG_IRQ_MASK, 16'h0001);
    wr(torque_limit_pkg::REG_HOME, 16'h0001);
    want_servo <= 1'b1;
    tick(4);
    #1;
    chk_bit(home, 1'b1);
    chk_bit(base_en, 1'b1);
    tick(1);
    flt[0] <= 1'b1;
    tick(2);
    #1;
    chk_bit(base_en, 1'b0);
    tick(2);
    #1;
    chk_val({8'h00, code}, 16'h0032);
    chk_bit(home, 1'b0);
    chk_bit(irq, 1'b1);
    tick(1);
    flt[0]      <= 1'b0;
    homing_done <= 1'b1;
    tick(6);
    #1;
    chk_bit(alarm, 1'b1);
    chk_bit(home, 1'b0);
    tick(1);
    homing_done <= 1'b0;
    rd_chk(torque_limit_pkg::REG_IRQ_STAT, 16'h0005);
    #1;
    chk_bit(irq, 1'b0);
    tick(1);
    want_servo <= 1'b0;
    power_cycle();
    #1;
    chk_bit(alarm, 1'b0);
  endtask
  // each of the four fault contacts held across a power cycle must come back with its own code
  task automatic t_codes();
    logic [15:0] exp [4];
    exp = '{16'h0032, 16'h0050, 16'h0051, 16'h0030};
    for (int i = 0; i < 4; i++) begin
      tick(1);
      flt <= 4'(1 << i);
      power_cycle();
      tick(3);
      #1;
      chk_val({8'h00, code}, exp[i]);
      tick(1);
      flt <= 4'h0;
      power_cycle();
    end
  endtask
  task automatic t_uv();
    power_on <= 1'b0;
    tick(UVC / 2);
    power_on <= 1'b1;
    tick(UVC + 6);
    #1;
    chk_bit(alarm, 1'b0);
    tick(1);
    power_on <= 1'b0;
    tick(UVC + 6);
    #1;
    chk_val({8'h00, code}, 16'h0010);
    tick(1);
    power_on <= 1'b1;
    bus_v    <= 10'h0c9;
    power_cycle();
    tick(UVC + 6);
    #1;
    chk_bit(alarm, 1'b0);
    tick(1);
    bus_v <= 10'h0c8;
    tick(UVC + 6);
    #1;
    chk_val({8'h00, code}, 16'h0010);
    tick(1);
    bus_v <= 10'h12c;
    power_cycle();
  endtask

  task automatic finish_test();
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // whole sequence needs well under a thousand cycles
  initial begin
    #1_000_000;
    miscompares++;
    $display("ERROR t=%0t watchdog expired", $time);
    finish_test();
  end
  initial begin
    power_cycle();
    t_reset();
    t_select();
    t_clamp();
    t_alarm();
    t_codes();
    t_uv();
    finish_test();
  end
endmodule
`default_nettype wire
